/* File: reset_source_combiner.sv */
// reset source combiner: supply monitor, external pin, internal causes
// assumes APB master on pclk; cause inputs come from pclk logic
//
// Overview of operation
// - power-on reset held while supply monitor shows supply low
// - power-on reset ORed with the external reset pin
// - warm-up starts when the later of both sources releases
// - core and peripherals halted until warm-up completes
// - pin low at least 5 us resets; its rising edge starts warm-up
// - shared pin is the reset input after power-on
// - voltage-detection hit raises an internal reset
// - watchdog overflow raises an internal reset
// - oscillator setting that would deadlock raises an internal reset
// - flash access during flash standby raises an internal reset
// - corrupted trimming latch raises an internal reset
// - trimming loaded during warm-up; bad data sets trim fault flag
// - status records cause of internal resets, not power-on
// - status cleared only by pin reset, power-on reset or the keyed clear
// - clear bit then key 0x71 clears status; clear bit self-clears
// - disable bit set then key 0xB2 turns pin into a port
// - disable bit cleared then key 0xB2 restores reset function
// - warm-up counter counts pclk after reset release
// - reset during warm-up restarts the warm-up counter
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "rsc_defines.svh"
module reset_source_combiner import rsc_pkg::*; #(
  parameter int unsigned WARMUP_CYC = `RSC_WARMUP_CYC,
  parameter int unsigned EXT_MIN_CYC = `RSC_EXT_MIN_CYC,
  parameter int unsigned TRIM_W = 8
) (
  input wire logic pclk, // high_freq_osc_clock, 125 MHz
  input wire logic presetn, // async power-up reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic supply_ok, // supply above por_release_voltage
  input wire logic shared_reset_port_pin, // pin level, low = reset
  input wire fault_in_t fault_in, // internal unit indications
  input wire osc_cfg_t osc_cfg, // oscillator enable settings
  input wire logic [TRIM_W-1:0] trim_nvm_data, // trimming storage word
  input wire logic trim_nvm_bad, // trimming word fails its check
  output logic chip_rst_n, // device reset, active low
  output logic core_run, // cpu and peripherals may run
  output logic [TRIM_W-1:0] trim_latch, // latched trimming bits
  output logic port_pin_in, // pin level for port use
  output logic reset_pin_disable // pin serves as port
);

  localparam int unsigned EXT_W = $clog2(EXT_MIN_CYC + 1);

  // =========================================================
  // elaboration check
  if (EXT_MIN_CYC < 2 || TRIM_W < 1 || TRIM_W > 32) begin : g_bad
    $error("reset_source_combiner: bad parameter value");
  end

  // =========================================================
  // pin synchronisers
  logic [1:0] sync1_q, sync2_q;
  logic por, pin_q;

  // both inputs are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 2'h1; // pin idles high, no false low after reset
      sync2_q <= 2'h1;
    end else begin
      sync1_q <= {supply_ok, shared_reset_port_pin};
      sync2_q <= sync1_q;
    end
  end

  assign por = !sync2_q[1];
  assign pin_q = sync2_q[0];

  // =========================================================
  // external reset with minimum low time
  logic [EXT_W-1:0] ext_cnt_q;
  logic ext_rst_q, reset_pin_disable_q;

  // short glitches on the pin never reach the device reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_q <= '0;
      ext_rst_q <= 1'b0;
    end else if (pin_q || reset_pin_disable_q) begin
      ext_cnt_q <= '0;
      ext_rst_q <= 1'b0;
    end else if (ext_cnt_q != EXT_W'(EXT_MIN_CYC - 1)) begin
      ext_cnt_q <= ext_cnt_q + EXT_W'(1);
    end else begin
      ext_rst_q <= 1'b1;
    end
  end

  logic hard_rst;
  assign hard_rst = por | ext_rst_q;

  // =========================================================
  // internal causes
  cause_t hit;
  logic int_trig, int_rst_q;

  always_comb begin
    hit.vdet = fault_in.vdet_hit;
    hit.wdt = fault_in.wdt_overflow;
    hit.clk = osc_cfg.sys_clk_lf ? !osc_cfg.lf_osc_en
                                 : !osc_cfg.hf_osc_en;
    hit.trim = fault_in.trim_corrupt;
    hit.flash = fault_in.flash_standby & fault_in.flash_access;
  end

  // a hard reset overrides; its cause is not recorded
  assign int_trig = (|hit) && !hard_rst;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_rst_q <= 1'b0;
    end else begin
      int_rst_q <= int_trig;
    end
  end

  // =========================================================
  // reset / warm-up / run sequence
  rst_state_t state_q;
  logic wu_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RESET;
    end else if (hard_rst || int_rst_q) begin
      state_q <= ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q <= ST_WARMUP;
        end
        ST_WARMUP: begin
          if (wu_done) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // counter runs only in warm-up, so any reset restarts it
  warmup_timer #(
    .CYCLES(WARMUP_CYC)
  ) u_warmup (
    .clk(pclk),
    .rst_n(presetn),
    .hold(state_q != ST_WARMUP),
    .done(wu_done)
  );

  assign chip_rst_n = (state_q != ST_RESET);
  assign core_run = (state_q == ST_RUN);

  // =========================================================
  // trimming load during warm-up
  logic trim_loaded_q, trim_set;
  logic [TRIM_W-1:0] trim_q;

  assign trim_set = (state_q == ST_WARMUP) && !trim_loaded_q
                    && !hard_rst && trim_nvm_bad;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_loaded_q <= 1'b0;
      trim_q <= '0;
    end else if (state_q == ST_RESET) begin
      trim_loaded_q <= 1'b0;
    end else if (state_q == ST_WARMUP && !trim_loaded_q) begin
      trim_loaded_q <= 1'b1;
      trim_q <= trim_nvm_data;
    end
  end

  assign trim_latch = trim_q;

  // =========================================================
  // apb slave, one cycle answer
  logic setup, access, wr_en, key_wr, addr_ok;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdata_d;
  logic [`RSC_CAUSE_W:0] status_q, status_d;
  logic clr_bit_q, pindis_pend_q, clear_fire, dis_fire;

  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite && !pslverr_q;
  assign key_wr = wr_en && (paddr == `RSC_OFF_KEY);
  assign clear_fire = key_wr && clr_bit_q
                      && (pwdata[7:0] == `RSC_KEY_CLEAR);
  assign dis_fire = key_wr && (pwdata[7:0] == `RSC_KEY_PINDIS);

  // read mux; bit 7 of the cause register reads zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      `RSC_OFF_CAUSE: begin
        rdata_d[`RSC_CAUSE_W:0] = status_q;
        rdata_d[`RSC_BIT_CLR] = clr_bit_q;
      end
      `RSC_OFF_CTRL3: begin
        rdata_d[`RSC_BIT_PINDIS] = pindis_pend_q;
      end
      `RSC_OFF_KEY: begin
        rdata_d = 32'h0000_0000;
      end
      `RSC_OFF_STATE: begin
        rdata_d[3:0] = {state_q, reset_pin_disable_q, pin_q};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // answer registered in setup, shown through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !addr_ok;
      if (setup) begin
        prdata_q <= rdata_d;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  // =========================================================
  // pending control bits, cleared by any device reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_bit_q <= 1'b0;
      pindis_pend_q <= 1'b0;
    end else if (hard_rst || int_rst_q) begin
      clr_bit_q <= 1'b0;
      pindis_pend_q <= 1'b0;
    end else if (clear_fire) begin
      clr_bit_q <= 1'b0;
    end else if (wr_en && paddr == `RSC_OFF_CAUSE) begin
      clr_bit_q <= pwdata[`RSC_BIT_CLR];
    end else if (wr_en && paddr == `RSC_OFF_CTRL3) begin
      pindis_pend_q <= pwdata[`RSC_BIT_PINDIS];
    end
  end

  // active pin function changes only through the key or a power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_disable_q <= 1'b0;
    end else if (por) begin
      reset_pin_disable_q <= 1'b0;
    end else if (dis_fire) begin
      reset_pin_disable_q <= pindis_pend_q;
    end
  end

  assign reset_pin_disable = reset_pin_disable_q;
  assign port_pin_in = pin_q;

  // =========================================================
  // reset_cause_status; a new cause wins over a keyed clear
  always_comb begin
    status_d = clear_fire ? `RSC_STAT_RST : status_q;
    if (int_trig) begin
      status_d[`RSC_CAUSE_W-1:0] = status_d[`RSC_CAUSE_W-1:0] | hit;
    end
    if (trim_set) begin
      status_d[`RSC_BIT_TRIMF] = 1'b1;
    end
  end

  // internal resets leave the flags alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `RSC_STAT_RST;
    end else if (hard_rst) begin
      status_q <= `RSC_STAT_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_por_hold: assert property (por |=> state_q == ST_RESET)
    else $error("supply low but device left reset");
  chk_or_combine: assert property (
    (por || ext_rst_q) |=> !chip_rst_n ##0 !core_run)
    else $error("combined reset not applied");
  chk_warmup_start: assert property (
    (state_q == ST_RESET && !hard_rst && !int_rst_q)
    |=> state_q == ST_WARMUP)
    else $error("warm-up did not start on release");
  chk_halt_warmup: assert property (
    state_q == ST_WARMUP |-> !core_run && chip_rst_n)
    else $error("core running during warm-up");
  chk_ext_low_time: assert property (
    $rose(ext_rst_q) |-> !$past(pin_q, 1)
    && $past(ext_cnt_q) == EXT_W'(EXT_MIN_CYC - 1))
    else $error("pin reset taken before least low time");
  chk_default_pin: assert property (por |=> !reset_pin_disable)
    else $error("pin not reset input after power-on");
  chk_int_reset: assert property (
    int_trig |=> int_rst_q ##1 state_q == ST_RESET)
    else $error("internal cause did not reset device");
  chk_cause_record: assert property (
    int_trig |=> (status_q[`RSC_CAUSE_W-1:0] & $past(hit))
    == $past(hit))
    else $error("internal cause not recorded");
  chk_hard_init: assert property (
    hard_rst |=> status_q == `RSC_STAT_RST)
    else $error("status kept through pin or power-on reset");
  chk_key_clear: assert property (
    (clear_fire && !int_trig && !trim_set && !hard_rst)
    |=> status_q == `RSC_STAT_RST && !clr_bit_q)
    else $error("keyed clear failed");
  chk_pin_key: assert property (
    (dis_fire && !por) |=> reset_pin_disable == $past(pindis_pend_q))
    else $error("pin function not committed by key");
  chk_key_exact: assert property (
    (key_wr && pwdata[7:0] != `RSC_KEY_PINDIS && !por)
    |=> $stable(reset_pin_disable))
    else $error("wrong key changed pin function");
  chk_restart: assert property (
    (state_q == ST_WARMUP && (hard_rst || int_rst_q))
    |=> state_q == ST_RESET ##1 !wu_done)
    else $error("warm-up not restarted by reset");
  chk_flags_kept: assert property (
    (int_rst_q && !hard_rst && !clear_fire)
    |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("cause flag lost on internal reset");

  cov_run: cover property (state_q == ST_WARMUP ##1 state_q == ST_RUN);
  cov_int: cover property (state_q == ST_RUN && int_trig);
  cov_clear: cover property (clear_fire);
  cov_pin_port: cover property (dis_fire && pindis_pend_q);

endmodule : reset_source_combiner

/* File: rsc_defines.svh */
// constants for the reset source combiner: offsets, fields, keys, times
// assumes a 125 MHz pclk and a 12-bit APB byte address
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH

// register byte offsets
`define RSC_OFF_CAUSE 12'h000
`define RSC_OFF_CTRL3 12'h004
`define RSC_OFF_KEY 12'h008
`define RSC_OFF_STATE 12'h00C

// reset_cause_status fields
`define RSC_CAUSE_W 5
`define RSC_BIT_TRIMF 5
`define RSC_BIT_CLR 6
`define RSC_STAT_RST 6'h00

// system_control_three field
`define RSC_BIT_PINDIS 0

// key codes written to key_code_register
`define RSC_KEY_CLEAR 8'h71
`define RSC_KEY_PINDIS 8'hB2

// timing: clock period, least pin low time, warm-up time
`define RSC_CLK_NS 8
`define RSC_EXT_MIN_NS 5000
`define RSC_EXT_MIN_CYC ((`RSC_EXT_MIN_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_WARMUP_NS 100000
`define RSC_WARMUP_CYC ((`RSC_WARMUP_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)

`endif

/* File: rsc_pkg.sv */
// types shared by the reset source combiner files
// assumes rsc_defines.svh carries the numbers
package rsc_pkg;

  // one bit per internal reset cause, msb first as in the status register
  typedef struct packed {
    logic flash;
    logic trim;
    logic clk;
    logic wdt;
    logic vdet;
  } cause_t;

  // raw indications from the surrounding units, same clock
  typedef struct packed {
    logic vdet_hit;
    logic wdt_overflow;
    logic trim_corrupt;
    logic flash_standby;
    logic flash_access;
  } fault_in_t;

  // oscillator enables and system clock source
  typedef struct packed {
    logic hf_osc_en;
    logic lf_osc_en;
    logic sys_clk_lf;
  } osc_cfg_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_WARMUP = 2'b01,
    ST_RUN = 2'b10
  } rst_state_t;

endpackage : rsc_pkg

/* File: warmup_timer.sv */
// warm-up counter: counts pclk cycles while not held
// assumes hold is high for the whole of any reset
`timescale 1ns/1ps
module warmup_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk, // high_freq_osc_clock
  input wire logic rst_n, // async, active low
  input wire logic hold, // clears and stops the count
  output logic done // warm-up complete, level
);

  localparam int unsigned W = $clog2(CYCLES + 1);

  // =========================================================
  // elaboration check
  if (CYCLES < 2) begin : g_bad
    $error("warmup_timer: CYCLES must be at least 2");
  end

  logic [W-1:0] cnt_q;

  // any hold restarts the count from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (hold) begin
      cnt_q <= '0;
    end else if (cnt_q != W'(CYCLES - 1)) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign done = !hold && (cnt_q == W'(CYCLES - 1));

endmodule : warmup_timer

/* File: board_reset_model.sv */
// board reset circuitry model driving the shared reset/port pin
// assumes the bench raises hold_low to request a reset pulse
`timescale 1ns/1ps
module board_reset_model #(
  parameter int unsigned MIN_LOW = 4
) (
  input wire logic clk, // high_freq_osc_clock
  input wire logic hold_low, // bench asks for the pin low
  output logic pin // pin level, pulled up when released
);
  // ========================================================
  // pulse shaping
  int unsigned low_cnt;
  initial pin = 1'b1;
  initial low_cnt = 0;
  // low stretched past the minimum plus sync slack, so a short
  // request never makes a pulse the device may ignore
  always @(posedge clk) begin
    if (hold_low) begin
      pin <= 1'b0;
      low_cnt <= 0;
    end else if (!pin && low_cnt < MIN_LOW + 3) begin
      low_cnt <= low_cnt + 1;
    end else begin
      pin <= 1'b1;
    end
  end
endmodule : board_reset_model

/* File: reset_source_combiner_tb.sv */
// self-checking bench for the reset source combiner
// assumes the board model on the pin and an APB master task
`timescale 1ns/1ps
`include "rsc_defines.svh"
module reset_source_combiner_tb import rsc_pkg::*;;
  localparam int unsigned W = 20;
  localparam int unsigned M = 4;
  localparam int LIMIT = 6000;
  typedef struct packed {
    fault_in_t f;
    osc_cfg_t o;
    logic [5:0] c;
  } row_t;
  localparam row_t ROWS [5] = '{'{5'b10000, 3'b100, 6'h01},
    '{5'b01000, 3'b100, 6'h02}, '{5'b00000, 3'b101, 6'h04},
    '{5'b00100, 3'b100, 6'h08}, '{5'b00011, 3'b100, 6'h10}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, supply_ok = 1'b0, pin, hold_low = 1'b1;
  fault_in_t fault_in = '0;
  osc_cfg_t osc_cfg = 3'b100;
  logic [7:0] trim_nvm_data = 8'hA5;
  logic trim_nvm_bad = 1'b0;
  logic chip_rst_n, core_run, port_pin_in, reset_pin_disable;
  logic [7:0] trim_latch;
  logic [31:0] rd;
  logic err;
  logic [5:0] exp_c;
  int num_errors = 0, samples_checked = 0, cyc = 0, n;

  always #4 pclk = ~pclk;

  reset_source_combiner #(.WARMUP_CYC(W), .EXT_MIN_CYC(M)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
    .shared_reset_port_pin(pin), .fault_in(fault_in),
    .osc_cfg(osc_cfg), .trim_nvm_data(trim_nvm_data),
    .trim_nvm_bad(trim_nvm_bad), .chip_rst_n(chip_rst_n),
    .core_run(core_run), .trim_latch(trim_latch),
    .port_pin_in(port_pin_in), .reset_pin_disable(reset_pin_disable));

  board_reset_model #(.MIN_LOW(M)) board (.clk(pclk),
    .hold_low(hold_low), .pin(pin));

  // ========================================================
  // reporting
  task automatic end_sim;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // hang guard: counts as a mismatch, then the closing report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end

  // ========================================================
  // drivers
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle limit here; the hang guard ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // waits for chip_rst_n (sel 0) or core_run (sel 1) to reach v
  task automatic wait_lvl(input int sel, input logic v, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (((sel == 0) ? chip_rst_n : core_run) !== v && c < 200);
  endtask : wait_lvl

  task automatic warmup_len;
    wait_lvl(0, 1'b1, n);
    wait_lvl(1, 1'b1, n);
    check("warmup length", n, W);
  endtask : warmup_len

  // ========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check("rst while supply low", chip_rst_n, 1'b0);
    check("pin function at power", reset_pin_disable, 1'b0);
    // board has held the pin low since power-up
    supply_ok <= 1'b1;
    repeat (12) @(posedge pclk);
    check("rst while pin low", chip_rst_n, 1'b0);
    check("halted in reset", core_run, 1'b0);
    hold_low <= 1'b0;
    warmup_len();
    check("trim latch", trim_latch, 8'hA5);
    apb(1'b0, `RSC_OFF_STATE, 0);
    check("state reg", rd, 32'h9);
    apb(1'b0, `RSC_OFF_CAUSE, 0);
    check("cause after power on", rd, 32'h0);
    // one row per internal cause; flags pile up across resets
    exp_c = 6'h00;
    for (int i = 0; i < 5; i++) begin
      fault_in <= ROWS[i].f;
      osc_cfg <= ROWS[i].o;
      @(posedge pclk);
      fault_in <= '0;
      osc_cfg <= 3'b100;
      wait_lvl(0, 1'b0, n);
      check("internal reset latency", n, 2);
      warmup_len();
      exp_c |= ROWS[i].c;
      apb(1'b0, `RSC_OFF_CAUSE, 0);
      check("cause flags", rd, {26'h0, exp_c});
    end
    // keyed clear: wrong key first, then the real one
    apb(1'b1, `RSC_OFF_CAUSE, 32'h40);
    apb(1'b1, `RSC_OFF_KEY, 32'h72);
    apb(1'b0, `RSC_OFF_CAUSE, 0);
    check("cause after bad key", rd, 32'h5F);
    apb(1'b1, `RSC_OFF_KEY, 32'h71);
    apb(1'b0, `RSC_OFF_CAUSE, 0);
    check("cause after clear", rd, 32'h0);
    // pin reset wipes causes; bad trim load and restart in warm-up
    fault_in <= 5'b01000;
    @(posedge pclk);
    fault_in <= '0;
    wait_lvl(0, 1'b0, n);
    check("wdt reset latency", n, 2);
    warmup_len();
    trim_nvm_bad <= 1'b1;
    trim_nvm_data <= 8'h3C;
    hold_low <= 1'b1;
    @(posedge pclk);
    hold_low <= 1'b0;
    wait_lvl(0, 1'b0, n);
    check("pin reset seen", chip_rst_n, 1'b0);
    wait_lvl(0, 1'b1, n);
    repeat (5) @(posedge pclk);
    fault_in <= 5'b01000;
    @(posedge pclk);
    fault_in <= '0;
    wait_lvl(0, 1'b0, n);
    check("reset in warmup", core_run, 1'b0);
    warmup_len();
    trim_nvm_bad <= 1'b0;
    apb(1'b0, `RSC_OFF_CAUSE, 0);
    check("cause after pin reset", rd, 32'h22);
    check("trim latch reload", trim_latch, 8'h3C);
    // asynchronous reset in mid-run wipes flags, then a clean start
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("rst in presetn", chip_rst_n, 1'b0);
    check("trim in presetn", trim_latch, 8'h00);
    presetn <= 1'b1;
    warmup_len();
    apb(1'b0, `RSC_OFF_CAUSE, 0);
    check("cause after presetn", rd, 32'h0);
    check("trim after presetn", trim_latch, 8'h3C);
    // pin function: wrong key, disable, pin low ignored, restore
    apb(1'b1, `RSC_OFF_CTRL3, 32'h1);
    apb(1'b1, `RSC_OFF_KEY, 32'h71);
    check("disable wrong key", reset_pin_disable, 1'b0);
    apb(1'b1, `RSC_OFF_KEY, 32'hB2);
    check("pin disabled", reset_pin_disable, 1'b1);
    hold_low <= 1'b1;
    repeat (12) @(posedge pclk);
    check("port ignores low", chip_rst_n, 1'b1);
    check("port level", port_pin_in, 1'b0);
    hold_low <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(1'b1, `RSC_OFF_CTRL3, 32'h0);
    apb(1'b1, `RSC_OFF_KEY, 32'hB2);
    check("pin restored", reset_pin_disable, 1'b0);
    hold_low <= 1'b1;
    @(posedge pclk);
    hold_low <= 1'b0;
    wait_lvl(0, 1'b0, n);
    check("pin reset again", chip_rst_n, 1'b0);
    warmup_len();
    // unmapped address
    apb(1'b0, 12'h010, 0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    end_sim();
  end
endmodule : reset_source_combiner_tb
